// >>> hdl/uart_frame_loop_control.sv
// The AXI4-Lite register port was chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none
module uart_frame_loop_control #(
  parameter int unsigned AW         = 8,
  parameter int unsigned BIT_CYCLES = 16
) (
  input  wire logic          aclk,
  input  wire logic          aresetn,
  input  wire logic [AW-1:0] s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [AW-1:0] s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic          wait_mode,
  input  wire logic          rxd_level,
  input  wire logic          txd_level,
  output logic               txd_drive,
  output logic               txd_oe
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  localparam logic [15:0] LAST = 16'(BIT_CYCLES - 1);

  typedef struct packed {
    logic [7:0]             ffc;
    logic [7:0]             alt;
    logic                   te;
    logic                   re;
    logic                   rwu;
    logic                   alternate_map_select;
    logic                   t8;
    logic [7:0]             tdat;
    logic                   tfull;
    logic                   tc;
    logic                   rfull;
    logic                   idle_f;
    logic                   ovr;
    logic                   perr;
    logic [8:0]             rdat;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [1:0]             rresp;
    logic [31:0]            rdata;
    ufl_pkg::ufl_tx_state_t txs;
    logic [10:0]            tsh;
    logic [3:0]             tbits;
    logic [15:0]            tcnt;
  } ufl_top_st_t;

  ufl_top_st_t          st_ff;
  ufl_top_st_t          nxt_st;
  ufl_pkg::ufl_cfg_t    cfg;
  ufl_pkg::ufl_rx_evt_t rx_evt;
  logic                 halt;
  logic                 tx_line;
  logic                 rx_line;
  logic                 wr_go;
  logic                 rd_go;
  logic [2:0]           wr_idx;
  logic [2:0]           rd_idx;
  logic                 wr_map;
  logic                 rd_map;

  // ---------------------------------------------------------------------------
  // Mode decode and receive path selection
  // ---------------------------------------------------------------------------
  assign halt    = st_ff.ffc[ufl_pkg::FFC_HALT] & wait_mode;
  assign tx_line = (st_ff.te && st_ff.txs == ufl_pkg::TX_SHIFT) ? st_ff.tsh[0] : 1'b1;
  assign cfg.nine = st_ff.ffc[ufl_pkg::FFC_NINE];
  assign cfg.wake = st_ff.ffc[ufl_pkg::FFC_WAKE];
  assign cfg.idle_count_origin  = st_ff.ffc[ufl_pkg::FFC_ILT];
  assign cfg.pe   = st_ff.ffc[ufl_pkg::FFC_PE];
  assign cfg.odd  = st_ff.ffc[ufl_pkg::FFC_ODD];

  // Receiver input: pin, internal loop or shared transmit wire
  always_comb begin
    if (!st_ff.ffc[ufl_pkg::FFC_LOOP]) rx_line = rxd_level;
    else if (!st_ff.ffc[ufl_pkg::FFC_SRC]) rx_line = tx_line;
    else rx_line = txd_level;
  end

  // Transmit pin drive, released when disabled or halted
  assign txd_drive = tx_line;
  assign txd_oe    = st_ff.te & ~halt;

  // ---------------------------------------------------------------------------
  // Bus handshakes and address decode
  // ---------------------------------------------------------------------------
  assign wr_go  = s_axi_awvalid & s_axi_wvalid & ~st_ff.bvalid;
  assign rd_go  = s_axi_arvalid & ~st_ff.rvalid;
  assign s_axi_awready = wr_go;
  assign s_axi_wready  = wr_go;
  assign s_axi_arready = rd_go;
  assign wr_idx = s_axi_awaddr[ufl_pkg::IDX_MSB:ufl_pkg::IDX_LSB];
  assign rd_idx = s_axi_araddr[ufl_pkg::IDX_MSB:ufl_pkg::IDX_LSB];
  assign wr_map = (s_axi_awaddr >> (ufl_pkg::IDX_MSB + 1)) == '0 && wr_idx >= ufl_pkg::IDX_FFC;
  assign rd_map = (s_axi_araddr >> (ufl_pkg::IDX_MSB + 1)) == '0 && rd_idx >= ufl_pkg::IDX_FFC;
  assign s_axi_bvalid = st_ff.bvalid;
  assign s_axi_bresp  = st_ff.bresp;
  assign s_axi_rvalid = st_ff.rvalid;
  assign s_axi_rresp  = st_ff.rresp;
  assign s_axi_rdata  = st_ff.rdata;

  // ---------------------------------------------------------------------------
  // Receiver
  // ---------------------------------------------------------------------------
  ufl_rx #(
    .BIT_CYCLES (BIT_CYCLES)
  ) u_rx (
    .aclk    (aclk),
    .aresetn (aresetn),
    .en      (st_ff.re & ~halt),
    .rx_line (rx_line),
    .cfg     (cfg),
    .evt     (rx_evt)
  );

  // ---------------------------------------------------------------------------
  // Next state: registers, transmitter, bus answers
  // ---------------------------------------------------------------------------
  always_comb begin
    logic [8:0] chr;
    logic [7:0] rbyte;
    chr   = {st_ff.t8, st_ff.tdat};
    rbyte = 8'h00;
    nxt_st = st_ff;
    if (st_ff.bvalid && s_axi_bready) nxt_st.bvalid = 1'b0;
    if (st_ff.rvalid && s_axi_rready) nxt_st.rvalid = 1'b0;

    // Register writes; low map selected by the alternate map bit
    if (wr_go) begin
      nxt_st.bvalid = 1'b1;
      nxt_st.bresp  = wr_map ? ufl_pkg::RESP_OKAY : ufl_pkg::RESP_SLVERR;
      if (wr_map && s_axi_wstrb[0]) begin
        case (wr_idx)
          ufl_pkg::IDX_FFC: begin
            if (st_ff.alternate_map_select) nxt_st.alt = s_axi_wdata[7:0];
            else nxt_st.ffc = s_axi_wdata[7:0];
          end
          ufl_pkg::IDX_CTRL2: begin
            nxt_st.te  = s_axi_wdata[ufl_pkg::CTRL2_TE];
            nxt_st.re  = s_axi_wdata[ufl_pkg::CTRL2_RE];
            nxt_st.rwu = s_axi_wdata[ufl_pkg::CTRL2_RWU];
          end
          ufl_pkg::IDX_STAT1: begin
            if (s_axi_wdata[ufl_pkg::STAT1_IDL]) nxt_st.idle_f = 1'b0;
            if (s_axi_wdata[ufl_pkg::STAT1_OVR]) nxt_st.ovr = 1'b0;
            if (s_axi_wdata[ufl_pkg::STAT1_PER]) nxt_st.perr = 1'b0;
          end
          ufl_pkg::IDX_STAT2: nxt_st.alternate_map_select = s_axi_wdata[ufl_pkg::STAT2_MAP];
          ufl_pkg::IDX_DATH: nxt_st.t8 = s_axi_wdata[ufl_pkg::DATH_T8];
          ufl_pkg::IDX_DATL: begin
            if (!st_ff.tfull) begin
              nxt_st.tdat  = s_axi_wdata[7:0];
              nxt_st.tfull = 1'b1;
            end
          end
          default: nxt_st.bresp = ufl_pkg::RESP_SLVERR;
        endcase
      end
    end

    // Register reads; reading the low data byte empties the receiver
    if (rd_go) begin
      nxt_st.rvalid = 1'b1;
      nxt_st.rresp  = rd_map ? ufl_pkg::RESP_OKAY : ufl_pkg::RESP_SLVERR;
      if (rd_map) begin
        case (rd_idx)
          ufl_pkg::IDX_FFC: rbyte = st_ff.alternate_map_select ? st_ff.alt : st_ff.ffc;
          ufl_pkg::IDX_CTRL2: begin
            rbyte[ufl_pkg::CTRL2_TE]  = st_ff.te;
            rbyte[ufl_pkg::CTRL2_RE]  = st_ff.re;
            rbyte[ufl_pkg::CTRL2_RWU] = st_ff.rwu;
          end
          ufl_pkg::IDX_STAT1: begin
            rbyte[ufl_pkg::STAT1_TXE] = ~st_ff.tfull;
            rbyte[ufl_pkg::STAT1_TXC] = st_ff.tc;
            rbyte[ufl_pkg::STAT1_RXF] = st_ff.rfull;
            rbyte[ufl_pkg::STAT1_IDL] = st_ff.idle_f;
            rbyte[ufl_pkg::STAT1_OVR] = st_ff.ovr;
            rbyte[ufl_pkg::STAT1_PER] = st_ff.perr;
          end
          ufl_pkg::IDX_STAT2: rbyte[ufl_pkg::STAT2_MAP] = st_ff.alternate_map_select;
          ufl_pkg::IDX_DATH: begin
            rbyte[ufl_pkg::DATH_R8] = st_ff.rdat[8];
            rbyte[ufl_pkg::DATH_T8] = st_ff.t8;
          end
          ufl_pkg::IDX_DATL: begin
            rbyte        = st_ff.rdat[7:0];
            nxt_st.rfull = 1'b0;
          end
          default: rbyte = 8'h00;
        endcase
      end
      nxt_st.rdata = {24'h00_0000, rbyte};
    end

    // Receiver events win over software clears in the same cycle
    if (rx_evt.wake) nxt_st.rwu = 1'b0;
    if (rx_evt.idle && !st_ff.rwu) nxt_st.idle_f = 1'b1;
    if (rx_evt.done && (!st_ff.rwu || rx_evt.wake)) begin
      nxt_st.perr = nxt_st.perr | rx_evt.perr;
      if (st_ff.rfull && nxt_st.rfull) nxt_st.ovr = 1'b1;
      else begin
        nxt_st.rdat  = rx_evt.data;
        nxt_st.rfull = 1'b1;
      end
    end

    // Transmitter: load frame, then shift lsb first at the bit rate
    if (!halt && st_ff.te) begin
      case (st_ff.txs)
        ufl_pkg::TX_IDLE: begin
          if (st_ff.tfull) begin
            if (cfg.pe && cfg.nine) chr[8] = ^chr[7:0] ^ cfg.odd;
            else if (cfg.pe) chr[7] = ^chr[6:0] ^ cfg.odd;
            nxt_st.tsh   = cfg.nine ? {1'b1, chr, 1'b0} : {2'b11, chr[7:0], 1'b0};
            nxt_st.tbits = cfg.nine ? ufl_pkg::FRAME_BITS_9 : ufl_pkg::FRAME_BITS_8;
            nxt_st.tcnt  = '0;
            nxt_st.txs   = ufl_pkg::TX_SHIFT;
            nxt_st.tc    = 1'b0;
            nxt_st.tfull = 1'b0;
          end
        end
        ufl_pkg::TX_SHIFT: begin
          nxt_st.tcnt = st_ff.tcnt + 16'h0001;
          if (st_ff.tcnt == LAST) begin
            nxt_st.tcnt  = '0;
            nxt_st.tsh   = {1'b1, st_ff.tsh[10:1]};
            nxt_st.tbits = st_ff.tbits - 4'h1;
            if (st_ff.tbits == 4'h1) begin
              nxt_st.txs = ufl_pkg::TX_IDLE;
              nxt_st.tc  = 1'b1;
            end
          end
        end
        default: nxt_st.txs = ufl_pkg::TX_IDLE;
      endcase
    end else if (!st_ff.te) begin
      nxt_st.txs = ufl_pkg::TX_IDLE;
    end
  end

  // State register; everything, frame control included, clears to zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_ff     <= '0;
      st_ff.ffc <= ufl_pkg::FFC_RESET;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_normal_rx;
    !st_ff.ffc[ufl_pkg::FFC_LOOP] |-> rx_line == rxd_level;
  endproperty
  a_normal_rx: assert property (p_normal_rx) else $error("normal path wrong");

  property p_loop_rx;
    st_ff.ffc[ufl_pkg::FFC_LOOP] && !st_ff.ffc[ufl_pkg::FFC_SRC] |-> rx_line == tx_line;
  endproperty
  a_loop_rx: assert property (p_loop_rx) else $error("loop path wrong");

  property p_single_wire;
    st_ff.ffc[ufl_pkg::FFC_LOOP] && st_ff.ffc[ufl_pkg::FFC_SRC] |-> rx_line == txd_level;
  endproperty
  a_single_wire: assert property (p_single_wire) else $error("single-wire wrong");

  property p_halt;
    halt |-> !txd_oe ##1 ($stable(st_ff.tsh) && $stable(st_ff.tcnt));
  endproperty
  a_halt: assert property (p_halt) else $error("unit ran while halted");

  property p_tx_release;
    !st_ff.te |-> !txd_oe && txd_drive;
  endproperty
  a_tx_release: assert property (p_tx_release) else $error("pin driven while off");

  sequence s_start_bit;
    (!txd_drive || !txd_oe) [*2];
  endsequence

  property p_frame_len;
    $rose(st_ff.txs == ufl_pkg::TX_SHIFT) |->
      (st_ff.tbits == (cfg.nine ? ufl_pkg::FRAME_BITS_9 : ufl_pkg::FRAME_BITS_8)) ##0 s_start_bit;
  endproperty
  a_frame_len: assert property (p_frame_len) else $error("frame length wrong");

  property p_map_read;
    rd_go && rd_map && rd_idx == ufl_pkg::IDX_FFC && !st_ff.alternate_map_select
      |=> s_axi_rdata[7:0] == $past(st_ff.ffc) && s_axi_rvalid;
  endproperty
  a_map_read: assert property (p_map_read) else $error("control read wrong");

  property p_reset_val;
    $rose(aresetn) |-> st_ff.ffc == ufl_pkg::FFC_RESET && !txd_oe;
  endproperty
  a_reset_val: assert property (p_reset_val) else $error("reset value wrong");

endmodule : uart_frame_loop_control
`default_nettype wire

// >>> hdl/ufl_pkg.sv
`default_nettype none
package ufl_pkg;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [2:0] IDX_FFC   = 3'h2;
  localparam logic [2:0] IDX_CTRL2 = 3'h3;
  localparam logic [2:0] IDX_STAT1 = 3'h4;
  localparam logic [2:0] IDX_STAT2 = 3'h5;
  localparam logic [2:0] IDX_DATH  = 3'h6;
  localparam logic [2:0] IDX_DATL  = 3'h7;
  localparam int unsigned IDX_LSB  = 2;
  localparam int unsigned IDX_MSB  = 4;

  // ---------------------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------------------
  localparam int unsigned FFC_LOOP  = 7;
  localparam int unsigned FFC_HALT  = 6;
  localparam int unsigned FFC_SRC   = 5;
  localparam int unsigned FFC_NINE  = 4;
  localparam int unsigned FFC_WAKE  = 3;
  localparam int unsigned FFC_ILT   = 2;
  localparam int unsigned FFC_PE    = 1;
  localparam int unsigned FFC_ODD   = 0;
  localparam int unsigned CTRL2_TE  = 3;
  localparam int unsigned CTRL2_RE  = 2;
  localparam int unsigned CTRL2_RWU = 1;
  localparam int unsigned STAT1_TXE = 7;
  localparam int unsigned STAT1_TXC = 6;
  localparam int unsigned STAT1_RXF = 5;
  localparam int unsigned STAT1_IDL = 4;
  localparam int unsigned STAT1_OVR = 3;
  localparam int unsigned STAT1_PER = 0;
  localparam int unsigned STAT2_MAP = 7;
  localparam int unsigned DATH_R8   = 7;
  localparam int unsigned DATH_T8   = 6;
  localparam logic [7:0]  FFC_RESET = 8'h00;

  // ---------------------------------------------------------------------------
  // Frame lengths and bus responses
  // ---------------------------------------------------------------------------
  localparam logic [3:0] FRAME_BITS_8 = 4'hA;
  localparam logic [3:0] FRAME_BITS_9 = 4'hB;
  localparam logic [3:0] FRAME_OVERHEAD = 4'h2;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ---------------------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------------------
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ufl_rx_state_t;
  typedef enum logic {TX_IDLE, TX_SHIFT} ufl_tx_state_t;

  typedef struct packed {
    logic nine;
    logic wake;
    logic idle_count_origin;
    logic pe;
    logic odd;
  } ufl_cfg_t;

  typedef struct packed {
    logic       done;
    logic [8:0] data;
    logic       perr;
    logic       idle;
    logic       wake;
  } ufl_rx_evt_t;

endpackage : ufl_pkg
`default_nettype wire

// >>> hdl/ufl_rx.sv
`timescale 1ns/10ps
`default_nettype none
module ufl_rx #(
  parameter int unsigned BIT_CYCLES = 16
) (
  input  wire logic                 aclk,
  input  wire logic                 aresetn,
  input  wire logic                 en,
  input  wire logic                 rx_line,
  input  wire ufl_pkg::ufl_cfg_t    cfg,
  output var  ufl_pkg::ufl_rx_evt_t evt
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  localparam logic [15:0] LAST = 16'(BIT_CYCLES - 1);
  localparam logic [15:0] HALF = 16'(BIT_CYCLES / 2);

  typedef struct packed {
    ufl_pkg::ufl_rx_state_t st;
    logic [15:0]            cnt;
    logic [3:0]             bits;
    logic [8:0]             sh;
    logic [3:0]             ones;
    logic                   armed;
    ufl_pkg::ufl_rx_evt_t   evt;
  } ufl_rx_st_t;

  ufl_rx_st_t st_ff;
  ufl_rx_st_t nxt_st;

  // Receive engine: start detect, mid-bit sampling, idle counting
  always_comb begin
    logic       tick;
    logic [3:0] fbits;
    logic [8:0] data;
    logic       msb;
    tick   = (st_ff.cnt == LAST);
    fbits  = cfg.nine ? ufl_pkg::FRAME_BITS_9 : ufl_pkg::FRAME_BITS_8;
    data   = cfg.nine ? st_ff.sh : {1'b0, st_ff.sh[8:1]};
    msb    = cfg.nine ? data[8] : data[7];
    nxt_st = st_ff;
    nxt_st.evt = '0;
    if (!en) begin
      nxt_st.st    = ufl_pkg::RX_IDLE;
      nxt_st.cnt   = '0;
      nxt_st.ones  = '0;
      nxt_st.armed = 1'b0;
    end else begin
      case (st_ff.st)
        ufl_pkg::RX_IDLE: begin
          nxt_st.cnt = tick ? '0 : st_ff.cnt + 16'h0001;
          if (!rx_line) begin
            nxt_st.st  = ufl_pkg::RX_START;
            nxt_st.cnt = '0;
          end else if (tick && st_ff.ones != fbits) begin
            // Idle character: a full frame time of ones
            nxt_st.ones = st_ff.ones + 4'h1;
            if (st_ff.armed && nxt_st.ones == fbits) begin
              nxt_st.evt.idle = 1'b1;
              nxt_st.evt.wake = !cfg.wake;
              nxt_st.armed    = 1'b0;
            end
          end
        end
        ufl_pkg::RX_START: begin
          nxt_st.cnt = st_ff.cnt + 16'h0001;
          if (st_ff.cnt == HALF) begin
            nxt_st.cnt  = '0;
            nxt_st.bits = '0;
            nxt_st.ones = '0;
            nxt_st.st   = rx_line ? ufl_pkg::RX_IDLE : ufl_pkg::RX_DATA;
          end
        end
        ufl_pkg::RX_DATA: begin
          nxt_st.cnt = st_ff.cnt + 16'h0001;
          if (tick) begin
            nxt_st.cnt  = '0;
            nxt_st.sh   = {rx_line, st_ff.sh[8:1]};
            nxt_st.bits = st_ff.bits + 4'h1;
            // Ones inside the data count only when counting from the start bit
            if (!rx_line) nxt_st.ones = '0;
            else if (!cfg.idle_count_origin) nxt_st.ones = st_ff.ones + 4'h1;
            if (nxt_st.bits == fbits - ufl_pkg::FRAME_OVERHEAD) nxt_st.st = ufl_pkg::RX_STOP;
          end
        end
        ufl_pkg::RX_STOP: begin
          nxt_st.cnt = st_ff.cnt + 16'h0001;
          if (tick) begin
            nxt_st.cnt      = '0;
            nxt_st.st       = ufl_pkg::RX_IDLE;
            nxt_st.armed    = 1'b1;
            nxt_st.evt.done = 1'b1;
            nxt_st.evt.data = data;
            nxt_st.evt.perr = cfg.pe & (^data ^ cfg.odd);
            nxt_st.evt.wake = cfg.wake & msb;
            nxt_st.ones     = (cfg.idle_count_origin || !rx_line) ? '0 : st_ff.ones + 4'h1;
          end
        end
        default: nxt_st.st = ufl_pkg::RX_IDLE;
      endcase
    end
  end

  // State register
  always_ff @(posedge aclk) begin
    if (!aresetn) st_ff <= '0;
    else st_ff <= nxt_st;
  end

  assign evt = st_ff.evt;

  // ---------------------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_rx_parity;
    nxt_st.evt.done |=> evt.perr == ($past(cfg.pe) & (^evt.data ^ $past(cfg.odd)));
  endproperty
  a_rx_parity: assert property (p_rx_parity) else $error("parity flag wrong");

  property p_rx_wake;
    evt.wake |-> ($past(cfg.wake) ? (evt.done && ($past(cfg.nine) ? evt.data[8] : evt.data[7]))
                                  : evt.idle);
  endproperty
  a_rx_wake: assert property (p_rx_wake) else $error("wake source wrong");

  property p_rx_ilt;
    (st_ff.st == ufl_pkg::RX_STOP && st_ff.cnt == LAST && en && cfg.idle_count_origin) |=> st_ff.ones == 4'h0;
  endproperty
  a_rx_ilt: assert property (p_rx_ilt) else $error("idle count not restarted");

endmodule : ufl_rx
`default_nettype wire

// >>> testbench/tb_top.sv
`timescale 1ns/10ps
`default_nettype none
`define CHK(n,e,s) begin checks_done++; if ((s) !== (e)) begin mismatches++; \
  $display("FAIL %s exp %h got %h", n, e, s); end end
module tb_top;
  localparam int unsigned BC = 4;
  logic        aclk, aresetn, awv, wv, bready, arv, rready, wait_mode;
  logic        awready, wready, bvalid, arready, rvalid, rxd_level, txd_level, txd_drive, txd_oe;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  int          mismatches = 0, checks_done = 0, cyc = 0;
  uart_frame_loop_control #(.BIT_CYCLES(BC)) i_uart_frame_loop_control (.aclk(aclk),
    .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .wait_mode(wait_mode), .rxd_level(rxd_level),
    .txd_level(txd_level), .txd_drive(txd_drive), .txd_oe(txd_oe));
  ufl_remote i_ufl_remote (.aclk(aclk), .txd_drive(txd_drive), .txd_oe(txd_oe),
    .rxd_level(rxd_level), .txd_level(txd_level));
  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end
  // Cycle ceiling against hangs
  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      mismatches++;
      end_of_test();
    end
  end
  task automatic end_of_test;
    if (mismatches == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : end_of_test
  // Bus write, address and data offered together
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [1:0] er;
    er = (a[7:5] == 3'h0 && a[4:2] >= ufl_pkg::IDX_FFC) ? ufl_pkg::RESP_OKAY
                                                        : ufl_pkg::RESP_SLVERR;
    awaddr <= a;
    wdata <= {24'h00_0000, d};
    {awv, wv} <= 2'b11;
    do @(posedge aclk); while (awready !== 1'b1);
    {awv, wv} <= 2'b00;
    do @(posedge aclk); while (bvalid !== 1'b1);
    `CHK("bresp", er, bresp)
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic [1:0] r);
    araddr <= a;
    arv <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arv <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    d = rdata[7:0];
    r = rresp;
  endtask : rd
  task automatic rchk(input logic [7:0] a, input logic [7:0] e, input string n);
    logic [7:0] d;
    logic [1:0] r;
    rd(a, d, r);
    `CHK(n, e, d)
  endtask : rchk
  // Poll receive full flag
  task automatic rx_wait;
    logic [7:0] s;
    logic [1:0] r;
    s = 8'h00;
    for (int i = 0; i < 200 && s[5] !== 1'b1; i++) rd(8'h10, s, r);
  endtask : rx_wait
  task automatic t_map;
    logic [7:0] d;
    logic [1:0] r;
    rchk(8'h08, ufl_pkg::FFC_RESET, "ffc_reset");
    rd(8'h00, d, r);
    `CHK("unmapped_resp", ufl_pkg::RESP_SLVERR, r)
    wr(8'h00, 8'hFF);
    wr(8'h14, 8'h80);
    wr(8'h08, 8'h55);
    rchk(8'h08, 8'h55, "alt_reg");
    wr(8'h14, 8'h00);
    rchk(8'h08, 8'h00, "ffc_back");
  endtask : t_map
  // Transmit with receive pin held low, expect own frame back
  task automatic t_loop(input logic [7:0] f, input logic [7:0] d, input logic [7:0] e,
                        input logic t8);
    wr(8'h08, f);
    i_ufl_remote.level(1'b0);
    wr(8'h0C, 8'h0C);
    wr(8'h18, {1'b0, t8, 6'h00});
    wr(8'h1C, d);
    rx_wait();
    rchk(8'h1C, e, "loop_data");
    if (f[4]) rchk(8'h18, {t8, t8, 6'h00}, "bit_eight");
    i_ufl_remote.level(1'b1);
  endtask : t_loop
  task automatic t_normal;
    wr(8'h08, 8'h20);
    i_ufl_remote.send(9'h03C, 8, BC);
    rx_wait();
    rchk(8'h1C, 8'h3C, "normal_data");
    repeat (12 * BC) @(posedge aclk);
    rchk(8'h10, 8'hD0, "status_idle");
  endtask : t_normal
  task automatic t_halt;
    wr(8'h08, 8'h40);
    wait_mode <= 1'b1;
    repeat (2) @(posedge aclk);
    `CHK("oe_halt", 1'b0, txd_oe)
    wr(8'h08, 8'h00);
    repeat (2) @(posedge aclk);
    `CHK("oe_wait", 1'b1, txd_oe)
    `CHK("tx_idle", 1'b1, txd_drive)
    wait_mode <= 1'b0;
  endtask : t_halt
  initial begin
    {aresetn, awv, wv, arv, wait_mode} = 5'b00000;
    {bready, rready} = 2'b11;
    {awaddr, araddr, wdata} = 48'h0000_0000_0000;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("oe_reset", 1'b0, txd_oe)
    t_map();
    t_loop(8'h80, 8'hA5, 8'hA5, 1'b0);
    t_loop(8'h90, 8'h5A, 8'h5A, 1'b1);
    t_loop(8'hA0, 8'hC3, 8'hC3, 1'b0);
    t_loop(8'h83, 8'h03, 8'h83, 1'b0);
    t_loop(8'h82, 8'h07, 8'h87, 1'b0);
    t_normal();
    t_halt();
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire

// >>> testbench/ufl_remote.sv
`timescale 1ns/10ps
`default_nettype none
module ufl_remote (
  input  wire logic aclk,
  input  wire logic txd_drive,
  input  wire logic txd_oe,
  output var  logic rxd_level,
  output var  logic txd_level
);
  logic last_tx;
  // Released wire shows the inverse of its last driven level
  always_comb txd_level = txd_oe ? txd_drive : ~last_tx;
  always @(posedge aclk) if (txd_oe) last_tx <= txd_drive;
  initial begin
    rxd_level = 1'b1;
    last_tx = 1'b1;
  end
  // Start low, data lsb first, stop high
  task automatic send(input logic [8:0] d, input int n, input int bc);
    for (int i = 0; i < n + 2; i++) begin
      rxd_level <= (i == 0) ? 1'b0 : (i == n + 1) ? 1'b1 : d[i-1];
      repeat (bc) @(posedge aclk);
    end
  endtask : send
  // Hold the receive line at a level
  task automatic level(input logic v);
    rxd_level <= v;
  endtask : level
endmodule : ufl_remote
`default_nettype wire
